// File: verilog/ccr_pkg.sv
// constants and carrier types of the charger configuration register bank
package ccr_pkg;

    // ************************************************************
    // register offsets on the serial port
    // ************************************************************
    localparam logic [7:0] CCR_OFF_PWR_CFG = 8'h01;
    localparam logic [7:0] CCR_OFF_CHG_CUR = 8'h02;
    localparam logic [7:0] CCR_OFF_PRE_TERM = 8'h03;
    localparam logic [7:0] CCR_OFF_CHG_VOLT = 8'h04;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CCR_REGRST_BIT = 7;
    localparam int CCR_FAST_LSB = 2;
    localparam int CCR_COLD_BIT = 1;
    localparam int CCR_FORCE_BIT = 0;
    localparam int CCR_PRE_LSB = 4;
    localparam int CCR_TERM_LSB = 0;
    localparam int CCR_VOLT_LSB = 2;
    localparam int CCR_LOWV_BIT = 1;
    localparam int CCR_RECHG_BIT = 0;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] CCR_CHG_CUR_RST = 8'h60;
    localparam logic [7:0] CCR_PRE_TERM_RST = 8'h11;
    localparam logic [7:0] CCR_CHG_VOLT_RST = 8'hB2;

    // ************************************************************
    // decode offsets and weights (mA, mV)
    // ************************************************************
    localparam logic [12:0] CCR_FAST_OFS_MA = 13'h0200;  // 512 mA
    localparam logic [12:0] CCR_FAST_STEP_MA = 13'h0040; // 64 mA
    localparam logic [12:0] CCR_FAST_DIV = 13'h0005;     // 20 % = 1/5
    localparam logic [11:0] CCR_PRE_OFS_MA = 12'h080;    // 128 mA
    localparam logic [11:0] CCR_PRE_STEP_MA = 12'h080;   // 128 mA
    localparam logic [11:0] CCR_TERM_OFS_MA = 12'h080;   // 128 mA
    localparam logic [11:0] CCR_TERM_STEP_MA = 12'h080;  // 128 mA
    localparam logic [12:0] CCR_VOLT_OFS_MV = 13'h0DB0;  // 3504 mV
    localparam logic [12:0] CCR_VOLT_STEP_MV = 13'h0010; // 16 mV
    localparam logic [11:0] CCR_LOWV_0_MV = 12'hAF0;     // 2800 mV
    localparam logic [11:0] CCR_LOWV_1_MV = 12'hBB8;     // 3000 mV
    localparam logic [8:0] CCR_RECHG_0_MV = 9'h064;      // 100 mV
    localparam logic [8:0] CCR_RECHG_1_MV = 9'h12C;      // 300 mV

    // decoded configuration handed to the regulation logic
    typedef struct packed {
        logic [12:0] fast_chg_ma;
        logic [12:0] fast_chg_applied_ma;
        logic [11:0] precharge_ma;
        logic [11:0] precharge_applied_ma;
        logic [11:0] term_ma;
        logic [12:0] charge_voltage_mv;
        logic [11:0] low_batt_threshold_mv;
        logic [8:0] recharge_offset_mv;
        logic boost_cold_sel;
        logic reduced_current_force;
    } ccr_cfg_t;

endpackage

// File: verilog/ccr_sync2.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps

module ccr_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // pins and synchronised copy
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // first stage feeds only the second one
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end else begin
            meta_ff <= d_in;
            q_ff <= meta_ff;
        end
    end

    assign q_out = q_ff;

endmodule

// File: verilog/ccr_wfield_dec.sv
// binary-weighted field decoder: offset plus the weights of the set bits
`timescale 1ns/1ps

module ccr_wfield_dec #(
    parameter int CW = 4,
    parameter int OW = 12,
    parameter logic [OW-1:0] OFFSET = '0,
    parameter logic [OW-1:0] STEP = '0
) (
    // field code and decoded value
    input wire logic [CW-1:0] code_in,
    output logic [OW-1:0] value_out
);

    logic [OW-1:0] acc;

    // each bit weighs STEP times its power of two
    always_comb begin
        acc = OFFSET;
        for (int i = 0; i < CW; i++) begin
            if (code_in[i]) begin
                acc = acc + (STEP << i);
            end
        end
        value_out = acc;
    end

endmodule

// File: verilog/ccr_cfg_regs.sv
// charger current and voltage configuration registers behind a serial slave port
`timescale 1ns/1ps

module ccr_cfg_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary slave address
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // serial port, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // decoded configuration
    output ccr_pkg::ccr_cfg_t cfg_out
);

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA} ccr_state_t;

    // ************************************************************
    // pin synchronisation and bus events
    // ************************************************************
    logic [1:0] pin_s;
    logic scl_q_ff;
    logic sda_q_ff;

    ccr_sync2 #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .d_in({scl_in, sda_in}),
        .q_out(pin_s)
    );

    // previous synchronised levels for edge detection
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= pin_s[1];
            sda_q_ff <= pin_s[0];
        end
    end

    wire scl_s = pin_s[1];
    wire sda_s = pin_s[0];
    wire scl_rise = scl_s & ~scl_q_ff;
    wire scl_fall = ~scl_s & scl_q_ff;
    wire start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    wire stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

    // ************************************************************
    // byte engine state
    // ************************************************************
    ccr_state_t state_ff;
    ccr_state_t nxt_state;
    logic [3:0] cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] ptr_ff;
    logic [7:0] tx_ff;
    logic mnack_ff;
    logic oe_ff;
    logic [7:0] chg_cur_ff;
    logic [7:0] pre_term_ff;
    logic [7:0] chg_volt_ff;

    // register read mux; unmapped and the reset-control byte read zero
    function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] c,
                                          input logic [7:0] p, input logic [7:0] v);
        rd_mux = (a == ccr_pkg::CCR_OFF_CHG_CUR) ? c :
                 (a == ccr_pkg::CCR_OFF_PRE_TERM) ? p :
                 (a == ccr_pkg::CCR_OFF_CHG_VOLT) ? v : 8'h00;
    endfunction

    // ack slot ends on the falling edge after the ninth rising edge
    wire byte_done = scl_fall & (cnt_ff == 4'h9);
    wire addr_hit = (shift_ff[7:1] == DEV_ADDR);
    wire wr_stb = byte_done & (state_ff == ST_WDATA);
    wire regrst_stb = wr_stb & (ptr_ff == ccr_pkg::CCR_OFF_PWR_CFG)
                      & shift_ff[ccr_pkg::CCR_REGRST_BIT];
    wire ack_now = ((state_ff == ST_ADDR) & addr_hit) | (state_ff == ST_REG)
                   | (state_ff == ST_WDATA);
    wire rd_start = byte_done & (state_ff == ST_ADDR) & addr_hit & shift_ff[0];
    wire rd_more = byte_done & (state_ff == ST_RDATA) & ~mnack_ff;
    wire [7:0] ptr_inc = ptr_ff + 8'h01;
    wire [7:0] ld_addr = (state_ff == ST_ADDR) ? ptr_ff : ptr_inc;
    wire [7:0] ld_data = rd_mux(ld_addr, chg_cur_ff, pre_term_ff, chg_volt_ff);

    // transitions happen only at start, stop or end of an ack slot
    always_comb begin
        nxt_state = state_ff;
        if (stop_det) begin
            nxt_state = ST_IDLE;
        end else if (start_det) begin
            nxt_state = ST_ADDR;
        end else if (byte_done) begin
            unique case (state_ff)
                ST_IDLE: nxt_state = ST_IDLE;
                ST_ADDR: nxt_state = !addr_hit ? ST_IDLE : (shift_ff[0] ? ST_RDATA : ST_REG);
                ST_REG: nxt_state = ST_WDATA;
                ST_WDATA: nxt_state = ST_WDATA;
                ST_RDATA: nxt_state = mnack_ff ? ST_IDLE : ST_RDATA;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // bit counter: eight data edges then the ack edge
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_ff <= 4'h0;
        end else if (start_det || byte_done) begin
            cnt_ff <= 4'h0;
        end else if (scl_rise && state_ff != ST_IDLE && cnt_ff != 4'h9) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // receive shifter and master acknowledge capture
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shift_ff <= 8'h00;
            mnack_ff <= 1'b1;
        end else if (scl_rise && cnt_ff < 4'h8) begin
            shift_ff <= {shift_ff[6:0], sda_s};
        end else if (scl_rise && cnt_ff == 4'h8) begin
            mnack_ff <= sda_s;
        end
    end

    // register pointer auto-increments after each written data byte and each acked read byte
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ptr_ff <= 8'h00;
        end else if (byte_done && state_ff == ST_REG) begin
            ptr_ff <= shift_ff;
        end else if (wr_stb || rd_more) begin
            ptr_ff <= ptr_inc;
        end
    end

    // data line drive: changes only while scl is low, so no false start/stop
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            oe_ff <= 1'b0;
            tx_ff <= 8'h00;
        end else if (start_det || stop_det) begin
            oe_ff <= 1'b0;
        end else if (rd_start || rd_more) begin
            tx_ff <= ld_data;
            oe_ff <= ~ld_data[7];
        end else if (byte_done) begin
            oe_ff <= 1'b0;
        end else if (scl_fall && cnt_ff == 4'h8) begin
            oe_ff <= ack_now & (state_ff != ST_RDATA);
        end else if (scl_fall && state_ff == ST_RDATA && cnt_ff != 4'h0) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
            oe_ff <= ~tx_ff[6];
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = oe_ff;

    // ************************************************************
    // configuration registers
    // ************************************************************
    // register reset reloads only these bytes; the state machine keeps going
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chg_cur_ff <= ccr_pkg::CCR_CHG_CUR_RST;
            pre_term_ff <= ccr_pkg::CCR_PRE_TERM_RST;
            chg_volt_ff <= ccr_pkg::CCR_CHG_VOLT_RST;
        end else if (regrst_stb) begin
            chg_cur_ff <= ccr_pkg::CCR_CHG_CUR_RST;
            pre_term_ff <= ccr_pkg::CCR_PRE_TERM_RST;
            chg_volt_ff <= ccr_pkg::CCR_CHG_VOLT_RST;
        end else if (wr_stb) begin
            // no range check: out-of-range codes are the host's to avoid
            if (ptr_ff == ccr_pkg::CCR_OFF_CHG_CUR) chg_cur_ff <= shift_ff;
            if (ptr_ff == ccr_pkg::CCR_OFF_PRE_TERM) pre_term_ff <= shift_ff;
            if (ptr_ff == ccr_pkg::CCR_OFF_CHG_VOLT) chg_volt_ff <= shift_ff;
        end
    end

    // ************************************************************
    // field decode
    // ************************************************************
    logic [12:0] fast_ma;
    logic [11:0] pre_ma;
    logic [11:0] term_ma;
    logic [12:0] volt_mv;
    ccr_pkg::ccr_cfg_t nxt_cfg;
    ccr_pkg::ccr_cfg_t cfg_ff;

    ccr_wfield_dec #(.CW(6), .OW(13), .OFFSET(ccr_pkg::CCR_FAST_OFS_MA),
                     .STEP(ccr_pkg::CCR_FAST_STEP_MA)) u_fast_dec (
        .code_in(chg_cur_ff[ccr_pkg::CCR_FAST_LSB +: 6]),
        .value_out(fast_ma)
    );
    ccr_wfield_dec #(.CW(4), .OW(12), .OFFSET(ccr_pkg::CCR_PRE_OFS_MA),
                     .STEP(ccr_pkg::CCR_PRE_STEP_MA)) u_pre_dec (
        .code_in(pre_term_ff[ccr_pkg::CCR_PRE_LSB +: 4]),
        .value_out(pre_ma)
    );
    ccr_wfield_dec #(.CW(4), .OW(12), .OFFSET(ccr_pkg::CCR_TERM_OFS_MA),
                     .STEP(ccr_pkg::CCR_TERM_STEP_MA)) u_term_dec (
        .code_in(pre_term_ff[ccr_pkg::CCR_TERM_LSB +: 4]),
        .value_out(term_ma)
    );
    ccr_wfield_dec #(.CW(6), .OW(13), .OFFSET(ccr_pkg::CCR_VOLT_OFS_MV),
                     .STEP(ccr_pkg::CCR_VOLT_STEP_MV)) u_volt_dec (
        .code_in(chg_volt_ff[ccr_pkg::CCR_VOLT_LSB +: 6]),
        .value_out(volt_mv)
    );

    // assemble the configuration; division by a constant stays small here
    always_comb begin
        nxt_cfg.fast_chg_ma = fast_ma;
        nxt_cfg.reduced_current_force = chg_cur_ff[ccr_pkg::CCR_FORCE_BIT];
        nxt_cfg.fast_chg_applied_ma = nxt_cfg.reduced_current_force ?
            13'(fast_ma / ccr_pkg::CCR_FAST_DIV) : fast_ma;
        nxt_cfg.precharge_ma = pre_ma;
        nxt_cfg.precharge_applied_ma = nxt_cfg.reduced_current_force ?
            (pre_ma >> 1) : pre_ma;
        nxt_cfg.term_ma = term_ma;
        nxt_cfg.charge_voltage_mv = volt_mv;
        nxt_cfg.low_batt_threshold_mv = chg_volt_ff[ccr_pkg::CCR_LOWV_BIT] ?
            ccr_pkg::CCR_LOWV_1_MV : ccr_pkg::CCR_LOWV_0_MV;
        nxt_cfg.recharge_offset_mv = chg_volt_ff[ccr_pkg::CCR_RECHG_BIT] ?
            ccr_pkg::CCR_RECHG_1_MV : ccr_pkg::CCR_RECHG_0_MV;
        nxt_cfg.boost_cold_sel = chg_cur_ff[ccr_pkg::CCR_COLD_BIT];
    end

    // registered so the analogue side sees glitch-free codes
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign cfg_out = cfg_ff;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking ccr_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    fast_decode_a: assert property (nxt_cfg.fast_chg_ma ==
        13'h0200 + 13'(chg_cur_ff[7:2]) * 13'h0040)
        else $error("fast charge decode wrong");
    reset_fast_a: assert property ($rose(resetn_in) |-> chg_cur_ff[7:2] == 6'h18
        && chg_cur_ff[1:0] == 2'h0)
        else $error("fast charge reset code wrong");
    cold_sel_a: assert property (##1 cfg_out.boost_cold_sel == $past(chg_cur_ff[1]))
        else $error("cold threshold select does not follow bit 1");
    reduced_fast_a: assert property (##1 $past(chg_cur_ff[0]) |->
        cfg_out.fast_chg_applied_ma * 13'h0005 + 13'(cfg_out.fast_chg_ma % 13'h0005)
        == cfg_out.fast_chg_ma && cfg_out.precharge_applied_ma == cfg_out.precharge_ma / 2)
        else $error("reduced current not applied");
    full_current_a: assert property (##1 !$past(chg_cur_ff[0]) |->
        cfg_out.fast_chg_applied_ma == cfg_out.fast_chg_ma
        && cfg_out.precharge_applied_ma == cfg_out.precharge_ma)
        else $error("current reduced without request");
    pre_term_dec_a: assert property (
        nxt_cfg.precharge_ma == 12'h080 * (12'(pre_term_ff[7:4]) + 12'h001)
        && nxt_cfg.term_ma == 12'h080 * (12'(pre_term_ff[3:0]) + 12'h001))
        else $error("pre-charge or termination decode wrong");
    volt_dec_a: assert property (nxt_cfg.charge_voltage_mv ==
        13'h0DB0 + 13'(chg_volt_ff[7:2]) * 13'h0010)
        else $error("charge voltage decode wrong");
    reset_bytes_a: assert property ($rose(resetn_in) |-> pre_term_ff == 8'h11
        && chg_volt_ff == 8'hB2)
        else $error("reset bytes wrong");
    volt_sel_a: assert property (nxt_cfg.low_batt_threshold_mv == (chg_volt_ff[1] ?
        12'hBB8 : 12'hAF0) && nxt_cfg.recharge_offset_mv == (chg_volt_ff[0] ? 9'h12C : 9'h064))
        else $error("threshold selects wrong");
    write_back_a: assert property (wr_stb && ptr_ff == 8'h04 |=>
        chg_volt_ff == $past(shift_ff))
        else $error("write not stored");
    hold_a: assert property (!wr_stb |=>
        $stable({chg_cur_ff, pre_term_ff, chg_volt_ff}))
        else $error("register changed without write");
    // the byte engine must stay in the write phase, not fall back to idle
    regrst_a: assert property (regrst_stb |=>
        chg_cur_ff == 8'h60 && pre_term_ff == 8'h11 && chg_volt_ff == 8'hB2
        && state_ff == ST_WDATA)
        else $error("register reset did not restore defaults");

    write_seen_c: cover property (wr_stb && ptr_ff == 8'h02);
    read_seen_c: cover property (rd_start ##[1:300] rd_more);
    regrst_seen_c: cover property (regrst_stb);

endmodule

// File: tb/ccr_host_model.sv
// serial port host model that drives the charger register bank
`timescale 1ns/1ps

module ccr_host_model (
    // clock
    input wire logic sys_clk_in,
    // serial wire, pulled up when released
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    // ************************************************************
    // bus phases
    // ************************************************************
    // scl stands still high between frames, line released
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // changes land just after an edge, never on it
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    // start or repeated start; eight clocks a phase for margin over four
    task automatic start_cond();
        sda_out = 1'b1;
        wait_clk(8);
        scl_out = 1'b1;
        wait_clk(8);
        sda_out = 1'b0;
        wait_clk(8);
        scl_out = 1'b0;
        wait_clk(4);
    endtask

    task automatic stop_cond();
        sda_out = 1'b0;
        wait_clk(8);
        scl_out = 1'b1;
        wait_clk(8);
        sda_out = 1'b1;
        wait_clk(8);
    endtask

    // one bit slot, wire sampled at the end of the high phase
    task automatic clk_bit(input logic b, output logic r);
        sda_out = b;
        wait_clk(8);
        scl_out = 1'b1;
        wait_clk(8);
        r = sda_in;
        scl_out = 1'b0;
        wait_clk(4);
    endtask

    // eight bits msb first, then the ack slot
    task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                             output logic [7:0] q, output logic ack_out);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
            q[i] = r;
        end
        clk_bit(ack_in, ack_out);
    endtask
endmodule

// File: tb/ccr_cfg_regs_tb_top.sv
// self-checking bench of the charger configuration register bank
`timescale 1ns/1ps

module ccr_cfg_regs_tb_top;
    localparam logic [6:0] ADDR = 7'h2A; // arbitrary slave address
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic scl;
    logic host_sda;
    logic sda_val;
    logic sda_oe;
    logic sda_wire;
    ccr_pkg::ccr_cfg_t cfg;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    // ************************************************************
    // clock, wire and instances
    // ************************************************************
    always #2 sys_clk = ~sys_clk;

    // open drain: either party pulls low, pull-up otherwise
    assign sda_wire = (sda_oe ? sda_val : 1'b1) & host_sda;

    ccr_cfg_regs #(.DEV_ADDR(ADDR)) u_ccr_cfg_regs (
        .sys_clk_in(sys_clk), .resetn_in(resetn), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_val), .sda_oe_out(sda_oe), .cfg_out(cfg));

    ccr_host_model u_ccr_host_model (
        .sys_clk_in(sys_clk), .sda_in(sda_wire), .scl_out(scl), .sda_out(host_sda));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // pointer then n data bytes; nak collects every missing ack
    task automatic wr(input logic [6:0] a, input logic [7:0] ptr, input int n,
                      input logic [23:0] d, output logic nak);
        logic [7:0] q;
        logic k;
        u_ccr_host_model.start_cond();
        u_ccr_host_model.xfer_byte({a, 1'b0}, 1'b1, q, nak);
        u_ccr_host_model.xfer_byte(ptr, 1'b1, q, k);
        nak = nak | k;
        for (int i = 0; i < n; i++) begin
            u_ccr_host_model.xfer_byte(d[23-8*i -: 8], 1'b1, q, k);
            nak = nak | k;
        end
        u_ccr_host_model.stop_cond();
    endtask

    // three bytes from ptr through a repeated start, last one nacked
    task automatic rd(input logic [7:0] ptr, output logic [23:0] q);
        logic [7:0] b;
        logic k;
        u_ccr_host_model.start_cond();
        u_ccr_host_model.xfer_byte({ADDR, 1'b0}, 1'b1, b, k);
        u_ccr_host_model.xfer_byte(ptr, 1'b1, b, k);
        u_ccr_host_model.start_cond();
        u_ccr_host_model.xfer_byte({ADDR, 1'b1}, 1'b1, b, k);
        for (int i = 0; i < 3; i++) begin
            u_ccr_host_model.xfer_byte(8'hFF, i == 2, b, k);
            q[23-8*i -: 8] = b;
        end
        u_ccr_host_model.stop_cond();
    endtask

    // decoded outputs worked out from the three register bytes
    task automatic chk_cfg(input logic [7:0] r2, input logic [7:0] r3, input logic [7:0] r4);
        logic [23:0] fast;
        logic [23:0] pre;
        fast = 24'h000200 + 24'h000040 * r2[7:2];
        pre = 24'h000080 + 24'h000080 * r3[7:4];
        check(cfg.fast_chg_ma, fast);
        check(cfg.fast_chg_applied_ma, r2[0] ? fast / 24'h000005 : fast);
        check(cfg.precharge_ma, pre);
        check(cfg.precharge_applied_ma, r2[0] ? pre >> 1 : pre);
        check(cfg.term_ma, 24'h000080 + 24'h000080 * r3[3:0]);
        check(cfg.charge_voltage_mv, 24'h000DB0 + 24'h000010 * r4[7:2]);
        check(cfg.low_batt_threshold_mv, r4[1] ? 24'h000BB8 : 24'h000AF0);
        check(cfg.recharge_offset_mv, r4[0] ? 24'h00012C : 24'h000064);
        check(cfg.boost_cold_sel, r2[1]);
        check(cfg.reduced_current_force, r2[0]);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_reset();
        logic [23:0] q;
        chk_cfg(8'h60, 8'h11, 8'hB2);
        rd(8'h02, q);
        check(q, 24'h6011B2);
        $display("test_reset done");
    endtask

    // fast charge codes kept at or below 39 by the host
    task automatic test_fields();
        logic [23:0] tbl [3];
        logic [23:0] q;
        logic nak;
        tbl = '{24'h9EFFDC, 24'h030003, 24'h9DA5E1};
        foreach (tbl[i]) begin
            wr(ADDR, 8'h02, 3, tbl[i], nak);
            check(nak, 1'b0);
            rd(8'h02, q);
            check(q, tbl[i]);
            chk_cfg(tbl[i][23:16], tbl[i][15:8], tbl[i][7:0]);
        end
        $display("test_fields done");
    endtask

    // register reset restores defaults, the bit itself reads back 0
    task automatic test_regreset();
        logic [23:0] q;
        logic nak;
        wr(ADDR, 8'h01, 1, 24'h800000, nak);
        check(nak, 1'b0);
        chk_cfg(8'h60, 8'h11, 8'hB2);
        rd(8'h01, q);
        check(q, 24'h006011);
        $display("test_regreset done");
    endtask

    // foreign address ignored; unmapped pointer acked, dropped, reads 0
    task automatic test_refused();
        logic [23:0] q;
        logic nak;
        wr(7'h15, 8'h02, 1, 24'h550000, nak);
        check(nak, 1'b1);
        wr(ADDR, 8'h05, 1, 24'hAA0000, nak);
        check(nak, 1'b0);
        rd(8'h02, q);
        check(q, 24'h6011B2);
        rd(8'h04, q);
        check(q, 24'hB20000);
        $display("test_refused done");
    endtask

    // ************************************************************
    // run control
    // ************************************************************
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard, well above the roughly 13000 cycles the tests take
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        test_reset();
        test_fields();
        test_regreset();
        test_refused();
        complete_run();
    end
endmodule
